// [hw/dpl_device.sv]
// Device end: shift register, divider latches and section control
//
// Function
// - Shift one data bit per serial clock rise
// - Load strobe copies word into selected latch
// - Four latches: tx/rx reference and program
// - Reference divider 14 bits, ratio 5..16383
// - Swallow counter 7 bits, 0..127
// - Program counter 11 bits, 5..2047
// - Prescaler 64/65 or 128/129, shared
// - Status shows monitor or lock by select
// - Polarity bit reverses phase detector sense
// - Tx sleep control low saves power
// - Rx sleep control low saves power, independently
// - Host holds sleep controls low at power-on
// - Switch output follows tx pump, else floats
// - Supply loss clears that section's latches; tx loss also clears shared mode bits
// - Host keeps swallow below program count
`timescale 1ns/1ns
`default_nettype none
module dpl_device (
    // Link side, clocked by the serial clock
    dpl_link_if.dev link,
    input wire logic resetn_i,
    // Section supplies, high while powered
    input wire logic tx_supply_ok_i,
    input wire logic rx_supply_ok_i,
    // Phase detector and lock sources
    input wire logic lock_detect_i,
    input wire logic phase_monitor_i,
    input wire logic tx_phase_up_i,
    input wire logic rx_phase_up_i,
    // Transmit divider settings
    output logic [dpl_pkg::DPL_REF_W-1:0] tx_ref_div_o,
    output logic [dpl_pkg::DPL_SWAL_W-1:0] tx_swallow_o,
    output logic [dpl_pkg::DPL_PROG_W-1:0] tx_prog_o,
    // Receive divider settings
    output logic [dpl_pkg::DPL_REF_W-1:0] rx_ref_div_o,
    output logic [dpl_pkg::DPL_SWAL_W-1:0] rx_swallow_o,
    output logic [dpl_pkg::DPL_PROG_W-1:0] rx_prog_o,
    // Shared mode bits
    output logic prescaler_128_o,
    output logic phase_polarity_o,
    output logic lock_output_select_o,
    // Section state and charge pump direction
    output logic tx_active_o,
    output logic rx_active_o,
    output logic tx_pump_o,
    output logic rx_pump_o
);
    import dpl_pkg::*;

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic [DPL_IN_N-1:0] sync1;
        logic [DPL_IN_N-1:0] sync2;
        logic [DPL_WORD_W-1:0] shift;
        logic [DPL_REF_W-1:0] tx_ref;
        logic [DPL_SWAL_W-1:0] tx_swal;
        logic [DPL_PROG_W-1:0] tx_prog;
        logic [DPL_REF_W-1:0] rx_ref;
        logic [DPL_SWAL_W-1:0] rx_swal;
        logic [DPL_PROG_W-1:0] rx_prog;
        logic psc128;
        logic polarity;
        logic lock_sel;
        logic tx_act;
        logic rx_act;
        logic tx_pump;
        logic rx_pump;
        logic status;
        logic sw_out;
        logic sw_oe;
    } dpl_dev_t;

    dpl_dev_t state_reg;
    dpl_dev_t state_next;
    logic [DPL_IN_N-1:0] raw_in;
    logic sel_sleep_tx;
    logic sel_sleep_rx;
    logic sel_sw;
    logic sel_sup_tx;
    logic sel_sup_rx;
    logic sel_lock;
    logic sel_phmon;
    logic sel_up_tx;
    logic sel_up_rx;
    dpl_sel_t dest;

    // ************************************************************
    // Inputs that arrive from outside the serial clock domain
    // ************************************************************
    always_comb begin
        raw_in = '0;
        raw_in[DPL_IN_SLEEP_TX] = link.tx_sleep_control;
        raw_in[DPL_IN_SLEEP_RX] = link.rx_sleep_control;
        raw_in[DPL_IN_SW_CTL] = link.tx_switch_control;
        raw_in[DPL_IN_SUP_TX] = tx_supply_ok_i;
        raw_in[DPL_IN_SUP_RX] = rx_supply_ok_i;
        raw_in[DPL_IN_LOCK] = lock_detect_i;
        raw_in[DPL_IN_PHMON] = phase_monitor_i;
        raw_in[DPL_IN_UP_TX] = tx_phase_up_i;
        raw_in[DPL_IN_UP_RX] = rx_phase_up_i;
    end

    assign sel_sleep_tx = state_reg.sync2[DPL_IN_SLEEP_TX];
    assign sel_sleep_rx = state_reg.sync2[DPL_IN_SLEEP_RX];
    assign sel_sw = state_reg.sync2[DPL_IN_SW_CTL];
    assign sel_sup_tx = state_reg.sync2[DPL_IN_SUP_TX];
    assign sel_sup_rx = state_reg.sync2[DPL_IN_SUP_RX];
    assign sel_lock = state_reg.sync2[DPL_IN_LOCK];
    assign sel_phmon = state_reg.sync2[DPL_IN_PHMON];
    assign sel_up_tx = state_reg.sync2[DPL_IN_UP_TX];
    assign sel_up_rx = state_reg.sync2[DPL_IN_UP_RX];
    assign dest = dpl_sel_t'(state_reg.shift[DPL_SEL_LSB +: DPL_SEL_W]);

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        state_next = state_reg;
        state_next.sync1 = raw_in;
        state_next.sync2 = state_reg.sync1;

        if (link.load_strobe) begin
            // Transfer edge: word goes to the latch its control bits name
            case (dest)
                DPL_SEL_TX_REF: begin
                    state_next.tx_ref =
                        state_reg.shift[DPL_REF_LSB +: DPL_REF_W];
                    state_next.psc128 = state_reg.shift[DPL_PSC_BIT];
                    state_next.polarity = state_reg.shift[DPL_POL_BIT];
                    state_next.lock_sel = state_reg.shift[DPL_LOCK_SEL_BIT];
                end
                DPL_SEL_TX_PROG: begin
                    state_next.tx_swal =
                        state_reg.shift[DPL_SWAL_LSB +: DPL_SWAL_W];
                    state_next.tx_prog =
                        state_reg.shift[DPL_PROG_LSB +: DPL_PROG_W];
                end
                DPL_SEL_RX_REF: begin
                    state_next.rx_ref =
                        state_reg.shift[DPL_REF_LSB +: DPL_REF_W];
                end
                DPL_SEL_RX_PROG: begin
                    state_next.rx_swal =
                        state_reg.shift[DPL_SWAL_LSB +: DPL_SWAL_W];
                    state_next.rx_prog =
                        state_reg.shift[DPL_PROG_LSB +: DPL_PROG_W];
                end
                default: begin
                    state_next.shift = state_reg.shift;
                end
            endcase
        end else begin
            // Plain shifting leaves every latch untouched
            state_next.shift = {state_reg.shift[DPL_WORD_W-2:0],
                                link.serial_data};
        end

        // A dead supply wipes its own section; a dead tx supply also wipes the shared mode bits
        if (!sel_sup_tx) begin
            state_next.tx_ref = '0;
            state_next.tx_swal = '0;
            state_next.tx_prog = '0;
            state_next.psc128 = 1'h0;
            state_next.polarity = 1'h0;
            state_next.lock_sel = 1'h0;
        end
        if (!sel_sup_rx) begin
            state_next.rx_ref = '0;
            state_next.rx_swal = '0;
            state_next.rx_prog = '0;
        end

        state_next.tx_act = sel_sleep_tx & sel_sup_tx;
        state_next.rx_act = sel_sleep_rx & sel_sup_rx;
        // Pump direction follows detector sense, reversed by polarity
        state_next.tx_pump = state_next.tx_act
            & (sel_up_tx ^ state_reg.polarity);
        state_next.rx_pump = state_next.rx_act
            & (sel_up_rx ^ state_reg.polarity);
        state_next.status = state_reg.lock_sel ? sel_phmon : sel_lock;
        state_next.sw_oe = sel_sw;
        state_next.sw_out = state_reg.tx_pump;
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge link.serial_clk or negedge resetn_i) begin
        if (!resetn_i) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign tx_ref_div_o = state_reg.tx_ref;
    assign tx_swallow_o = state_reg.tx_swal;
    assign tx_prog_o = state_reg.tx_prog;
    assign rx_ref_div_o = state_reg.rx_ref;
    assign rx_swallow_o = state_reg.rx_swal;
    assign rx_prog_o = state_reg.rx_prog;
    assign prescaler_128_o = state_reg.psc128;
    assign phase_polarity_o = state_reg.polarity;
    assign lock_output_select_o = state_reg.lock_sel;
    assign tx_active_o = state_reg.tx_act;
    assign rx_active_o = state_reg.rx_act;
    assign tx_pump_o = state_reg.tx_pump;
    assign rx_pump_o = state_reg.rx_pump;
    assign link.status_line = state_reg.status;
    assign link.tx_switch_out = state_reg.sw_out;
    assign link.tx_switch_oe = state_reg.sw_oe;
endmodule
`default_nettype wire

// [hw/dpl_host.sv]
// Host end: register port, word checks and serial link driver
`timescale 1ns/1ns
`default_nettype none
module dpl_host (
    // Clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // Register port
    input wire logic [dpl_pkg::DPL_ADDR_W-1:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic we_i,
    input wire logic re_i,
    output logic [31:0] rdata_o,
    // Link to the device
    dpl_link_if.host link
);
    import dpl_pkg::*;

    typedef enum logic [1:0] {
        DPL_ST_IDLE,
        DPL_ST_SHIFT,
        DPL_ST_LOAD
    } dpl_state_t;

    typedef struct packed {
        dpl_state_t state;
        logic [DPL_WORD_W-1:0] word;
        logic [DPL_BITCNT_W-1:0] bitcnt;
        logic [DPL_HCNT_W-1:0] cnt;
        logic sclk;
        logic sdata;
        logic strobe;
        logic [2:0] ctrl;
        logic err;
        logic [1:0] line_sync;
        logic [1:0] sw_sync;
        logic [31:0] rdata;
    } dpl_host_t;

    localparam logic [DPL_HCNT_W-1:0] HALF_M1 =
        DPL_HCNT_W'(DPL_SCLK_HALF_CYC - 1);
    localparam logic [DPL_BITCNT_W-1:0] LAST_BIT =
        DPL_BITCNT_W'(DPL_WORD_W - 1);

    dpl_host_t state_reg;
    dpl_host_t state_next;
    dpl_sel_t wsel;
    logic word_ok;

    // ************************************************************
    // Range checks on a word before it is sent
    // ************************************************************
    always_comb begin
        wsel = dpl_sel_t'(wdata_i[DPL_SEL_LSB +: DPL_SEL_W]);
        case (wsel)
            DPL_SEL_TX_REF, DPL_SEL_RX_REF: begin
                word_ok = wdata_i[DPL_REF_LSB +: DPL_REF_W]
                    >= DPL_REF_MIN;
            end
            default: begin
                word_ok = (wdata_i[DPL_PROG_LSB +: DPL_PROG_W]
                    >= DPL_PROG_MIN)
                    && ({4'h0, wdata_i[DPL_SWAL_LSB +: DPL_SWAL_W]}
                    < wdata_i[DPL_PROG_LSB +: DPL_PROG_W]);
            end
        endcase
    end

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        state_next = state_reg;
        state_next.line_sync = {state_reg.line_sync[0], link.status_line};
        state_next.sw_sync = {state_reg.sw_sync[0], link.tx_switch_output};
        state_next.rdata = '0;

        if (re_i) begin
            case (addr_i)
                DPL_REG_WORD: begin
                    state_next.rdata[DPL_WORD_W-1:0] = state_reg.word;
                end
                DPL_REG_CTRL: state_next.rdata[2:0] = state_reg.ctrl;
                DPL_REG_STAT: begin
                    state_next.rdata[DPL_STAT_BUSY] =
                        (state_reg.state != DPL_ST_IDLE);
                    state_next.rdata[DPL_STAT_ERR] = state_reg.err;
                    state_next.rdata[DPL_STAT_LINE] = state_reg.line_sync[1];
                    state_next.rdata[DPL_STAT_SWITCH] = state_reg.sw_sync[1];
                end
                default: state_next.rdata = '0;
            endcase
        end

        if (we_i && addr_i == DPL_REG_CTRL) begin
            state_next.ctrl = wdata_i[2:0];
        end

        case (state_reg.state)
            DPL_ST_IDLE: begin
                if (we_i && addr_i == DPL_REG_WORD) begin
                    if (word_ok) begin
                        state_next.word = wdata_i[DPL_WORD_W-1:0];
                        state_next.sdata = wdata_i[DPL_WORD_W-1];
                        state_next.bitcnt = LAST_BIT;
                        state_next.cnt = HALF_M1;
                        state_next.err = 1'h0;
                        state_next.state = DPL_ST_SHIFT;
                    end else begin
                        state_next.err = 1'h1;
                    end
                end
            end
            DPL_ST_SHIFT: begin
                if (state_reg.cnt != '0) begin
                    state_next.cnt = state_reg.cnt - 1'h1;
                end else begin
                    state_next.cnt = HALF_M1;
                    state_next.sclk = ~state_reg.sclk;
                    // Data moves on the falling edge, most significant first
                    if (state_reg.sclk) begin
                        if (state_reg.bitcnt == '0) begin
                            state_next.strobe = 1'h1;
                            state_next.state = DPL_ST_LOAD;
                        end else begin
                            state_next.bitcnt = state_reg.bitcnt - 1'h1;
                            state_next.sdata =
                                state_reg.word[state_reg.bitcnt - 1'h1];
                        end
                    end
                end
            end
            DPL_ST_LOAD: begin
                // One clock pulse with the strobe high moves the word
                if (state_reg.cnt != '0) begin
                    state_next.cnt = state_reg.cnt - 1'h1;
                end else begin
                    state_next.cnt = HALF_M1;
                    state_next.sclk = ~state_reg.sclk;
                    if (state_reg.sclk) begin
                        state_next.strobe = 1'h0;
                        state_next.state = DPL_ST_IDLE;
                    end
                end
            end
            default: state_next.state = DPL_ST_IDLE;
        endcase
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_reg <= '0;
            state_reg.ctrl <= DPL_CTRL_RST;
        end else begin
            state_reg <= state_next;
        end
    end

    assign rdata_o = state_reg.rdata;
    assign link.serial_clk = state_reg.sclk;
    assign link.serial_data = state_reg.sdata;
    assign link.load_strobe = state_reg.strobe;
    assign link.tx_sleep_control = state_reg.ctrl[DPL_CTRL_TX_SLEEP];
    assign link.rx_sleep_control = state_reg.ctrl[DPL_CTRL_RX_SLEEP];
    assign link.tx_switch_control = state_reg.ctrl[DPL_CTRL_SW];
endmodule
`default_nettype wire

// [hw/dpl_link_if.sv]
// Serial link between the host controller and the dual PLL device
`timescale 1ns/1ns
`default_nettype none
interface dpl_link_if;
    logic serial_clk;
    logic serial_data;
    logic load_strobe;
    logic tx_sleep_control;
    logic rx_sleep_control;
    logic tx_switch_control;
    logic status_line;
    logic tx_switch_out;
    logic tx_switch_oe;
    wire tx_switch_output;

    modport dev (
        input serial_clk, serial_data, load_strobe,
        input tx_sleep_control, rx_sleep_control, tx_switch_control,
        output status_line, tx_switch_out, tx_switch_oe
    );

    modport host (
        output serial_clk, serial_data, load_strobe,
        output tx_sleep_control, rx_sleep_control, tx_switch_control,
        input status_line, tx_switch_output
    );
endinterface
`default_nettype wire

// [hw/dpl_pkg.sv]
// Shared constants for the dual PLL serial divider loader
package dpl_pkg;

    // ************************************************************
    // Serial word and divider widths
    // ************************************************************
    localparam int DPL_WORD_W = 23;
    localparam int DPL_REF_W = 14;
    localparam int DPL_SWAL_W = 7;
    localparam int DPL_PROG_W = 11;
    localparam int DPL_SEL_W = 2;
    localparam int DPL_BITCNT_W = 5;

    // ************************************************************
    // Field positions inside the serial word
    // ************************************************************
    localparam int DPL_SEL_LSB = 0;
    localparam int DPL_REF_LSB = 2;
    localparam int DPL_PSC_BIT = 16;
    localparam int DPL_POL_BIT = 17;
    localparam int DPL_LOCK_SEL_BIT = 18;
    localparam int DPL_SWAL_LSB = 2;
    localparam int DPL_PROG_LSB = 9;

    // Destination latch selected by the control bits
    typedef enum logic [1:0] {
        DPL_SEL_TX_REF,
        DPL_SEL_TX_PROG,
        DPL_SEL_RX_REF,
        DPL_SEL_RX_PROG
    } dpl_sel_t;

    // Lowest legal divide ratios
    localparam logic [13:0] DPL_REF_MIN = 14'h0005;
    localparam logic [10:0] DPL_PROG_MIN = 11'h005;

    // ************************************************************
    // Positions of the synchronised device inputs
    // ************************************************************
    localparam int DPL_IN_SLEEP_TX = 0;
    localparam int DPL_IN_SLEEP_RX = 1;
    localparam int DPL_IN_SW_CTL = 2;
    localparam int DPL_IN_SUP_TX = 3;
    localparam int DPL_IN_SUP_RX = 4;
    localparam int DPL_IN_LOCK = 5;
    localparam int DPL_IN_PHMON = 6;
    localparam int DPL_IN_UP_TX = 7;
    localparam int DPL_IN_UP_RX = 8;
    localparam int DPL_IN_N = 9;

    // ************************************************************
    // Host timing
    // ************************************************************
    localparam int DPL_CLK_NS = 40;
    localparam int DPL_SCLK_HALF_NS = 80;
    localparam int DPL_SCLK_HALF_CYC = (DPL_SCLK_HALF_NS / DPL_CLK_NS < 1)
        ? 1 : DPL_SCLK_HALF_NS / DPL_CLK_NS;
    localparam int DPL_HCNT_W = 4;

    // ************************************************************
    // Host register map
    // ************************************************************
    localparam int DPL_ADDR_W = 4;
    localparam logic [3:0] DPL_REG_WORD = 4'h0;
    localparam logic [3:0] DPL_REG_CTRL = 4'h4;
    localparam logic [3:0] DPL_REG_STAT = 4'h8;
    localparam int DPL_CTRL_TX_SLEEP = 0;
    localparam int DPL_CTRL_RX_SLEEP = 1;
    localparam int DPL_CTRL_SW = 2;
    localparam logic [2:0] DPL_CTRL_RST = 3'h0;
    localparam int DPL_STAT_BUSY = 0;
    localparam int DPL_STAT_ERR = 1;
    localparam int DPL_STAT_LINE = 2;
    localparam int DPL_STAT_SWITCH = 3;

endpackage

// [sim/dpl_link_props.sv]
// Link checker for the dual PLL serial divider loader
`timescale 1ns/1ns
`default_nettype none
module dpl_link_props (
    // Host clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // Link signals
    input wire logic serial_clk_i,
    input wire logic serial_data_i,
    input wire logic load_strobe_i,
    input wire logic tx_sleep_control_i,
    input wire logic rx_sleep_control_i,
    input wire logic tx_switch_control_i,
    input wire logic tx_switch_oe_i
);
    strobe_clk_low_a: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        $rose(load_strobe_i) |-> !serial_clk_i)
        else $error("strobe rose high");
    strobe_len_a: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        $rose(load_strobe_i) |-> load_strobe_i[*4])
        else $error("strobe short");
    fall_together_a: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        $fell(load_strobe_i) |-> $fell(serial_clk_i))
        else $error("strobe end");
    clk_high_a: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        $rose(serial_clk_i) |-> serial_clk_i[*2] ##1 !serial_clk_i)
        else $error("clock high phase");
    clk_low_a: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        $fell(serial_clk_i) |-> (!serial_clk_i)[*2])
        else $error("clock low phase");
    data_hold_a: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        serial_clk_i && $past(serial_clk_i) |-> $stable(serial_data_i))
        else $error("data moved");
    sleep_boot_a: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        !$past(resetn_i) |-> !tx_sleep_control_i && !rx_sleep_control_i)
        else $error("sleep high at boot");
    switch_on_a: assert property (
        @(posedge serial_clk_i) disable iff (!resetn_i)
        tx_switch_control_i[*4] |-> tx_switch_oe_i)
        else $error("switch off");
    switch_off_a: assert property (
        @(posedge serial_clk_i) disable iff (!resetn_i)
        (!tx_switch_control_i)[*4] |-> !tx_switch_oe_i)
        else $error("switch on");
endmodule
`default_nettype wire

// [sim/tb_dual_pll_serial_divider_loader.sv]
// Self-checking bench for the dual PLL serial divider loader
`timescale 1ns/1ns
`default_nettype none
module tb_dual_pll_serial_divider_loader;
    import dpl_pkg::*;
    logic clk_i, resetn_i, we_i, re_i;
    logic [3:0] addr_i;
    logic [31:0] wdata_i, rdata_o, d;
    logic tx_sup, rx_sup, lock, mon, up_tx, up_rx;
    logic [13:0] tx_r, rx_r;
    logic [6:0] tx_a, rx_a;
    logic [10:0] tx_n, rx_n;
    logic psc, pol, lsel, tx_act, rx_act, tx_p, rx_p;
    int n_fail = 0, samples_checked = 0, cyc = 0;
    dpl_link_if link ();
    // Switch pin floats while the device does not drive it
    assign link.tx_switch_output =
        link.tx_switch_oe ? link.tx_switch_out : 1'bz;
    dpl_host dpl_host_inst (.clk_i(clk_i), .resetn_i(resetn_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .we_i(we_i), .re_i(re_i),
        .rdata_o(rdata_o), .link(link.host));
    dpl_device dpl_device_inst (.link(link.dev), .resetn_i(resetn_i),
        .tx_supply_ok_i(tx_sup), .rx_supply_ok_i(rx_sup),
        .lock_detect_i(lock), .phase_monitor_i(mon),
        .tx_phase_up_i(up_tx), .rx_phase_up_i(up_rx),
        .tx_ref_div_o(tx_r), .tx_swallow_o(tx_a), .tx_prog_o(tx_n),
        .rx_ref_div_o(rx_r), .rx_swallow_o(rx_a), .rx_prog_o(rx_n),
        .prescaler_128_o(psc), .phase_polarity_o(pol),
        .lock_output_select_o(lsel), .tx_active_o(tx_act),
        .rx_active_o(rx_act), .tx_pump_o(tx_p), .rx_pump_o(rx_p));
    dpl_link_props dpl_link_props_inst (.clk_i(clk_i), .resetn_i(resetn_i),
        .serial_clk_i(link.serial_clk), .serial_data_i(link.serial_data),
        .load_strobe_i(link.load_strobe),
        .tx_sleep_control_i(link.tx_sleep_control),
        .rx_sleep_control_i(link.rx_sleep_control),
        .tx_switch_control_i(link.tx_switch_control),
        .tx_switch_oe_i(link.tx_switch_oe));
    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end
    // ************************************************************
    // Bus and link helpers
    // ************************************************************
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail = n_fail + 1;
            print_verdict;
        end
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= v;
        we_i <= 1'b1;
        @(posedge clk_i);
        we_i <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge clk_i);
        addr_i <= a;
        re_i <= 1'b1;
        @(posedge clk_i);
        re_i <= 1'b0;
        #1 v = rdata_o;
    endtask
    task automatic send(input logic [31:0] w);
        logic [31:0] s;
        wr(DPL_REG_WORD, w);
        @(posedge clk_i);
        s = 32'h1;
        for (int i = 0; i < 200 && s[0] !== 1'b0; i++) rd(DPL_REG_STAT, s);
        check(32'(s[0]), 32'h0);
    endtask
    function automatic logic [31:0] rw(input logic [1:0] s,
        input logic [13:0] r, input logic [2:0] m);
        return {13'h0, m, r, s};
    endfunction
    function automatic logic [31:0] pw(input logic [1:0] s,
        input logic [10:0] n, input logic [6:0] a);
        return {12'h0, n, a, s};
    endfunction
    task automatic frame;
        send(pw(DPL_SEL_RX_PROG, 11'h005, 7'h04));
    endtask
    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_load;
        send(rw(DPL_SEL_TX_REF, 14'h0005, 3'h7));
        send(pw(DPL_SEL_TX_PROG, 11'h7FF, 7'h7F));
        send(rw(DPL_SEL_RX_REF, 14'h3FFF, 3'h0));
        frame;
        check(32'(tx_r), 32'h5);
        check({14'h0, tx_n, tx_a}, {14'h0, 11'h7FF, 7'h7F});
        check(32'(rx_r), 32'h3FFF);
        check({14'h0, rx_n, 7'(rx_a)}, {14'h0, 11'h005, 7'h04});
        check(32'({lsel, pol, psc}), 32'h7);
        rd(DPL_REG_STAT, d);
        check(32'(d[1]), 32'h0);
        rd(DPL_REG_WORD, d);
        check(d, pw(DPL_SEL_RX_PROG, 11'h005, 7'h04));
        rd(DPL_REG_CTRL, d);
        check(d, 32'h3);
    endtask
    task automatic t_bad;
        send(rw(DPL_SEL_TX_REF, 14'h0004, 3'h0));
        rd(DPL_REG_STAT, d);
        check(32'(d[1]), 32'h1);
        check(32'(tx_r), 32'h5);
        send(pw(DPL_SEL_TX_PROG, 11'h005, 7'h05));
        rd(DPL_REG_STAT, d);
        check(32'(d[1]), 32'h1);
        check(32'(tx_n), 32'h7FF);
    endtask
    task automatic t_status;
        frame;
        rd(DPL_REG_STAT, d);
        check(32'(d[2]), 32'(mon));
        send(rw(DPL_SEL_TX_REF, 14'h0005, 3'h3));
        frame;
        rd(DPL_REG_STAT, d);
        check(32'(d[2]), 32'(lock));
    endtask
    task automatic t_pump;
        up_rx <= 1'b0;
        frame;
        check(32'({tx_p, rx_p}), 32'h1);
        send(rw(DPL_SEL_TX_REF, 14'h0005, 3'h1));
        frame;
        check(32'({tx_p, rx_p}), 32'h2);
        up_rx <= 1'b1;
        wr(DPL_REG_CTRL, 32'h2);
        frame;
        check(32'({tx_act, tx_p}), 32'h0);
        check(32'({rx_act, rx_p}), 32'h3);
        wr(DPL_REG_CTRL, 32'h1);
        frame;
        check(32'({tx_act, rx_act}), 32'h2);
    endtask
    task automatic t_switch;
        wr(DPL_REG_CTRL, 32'h7);
        frame;
        check({31'h0, link.tx_switch_output}, {31'h0, tx_p});
        wr(DPL_REG_CTRL, 32'h3);
        frame;
        check({31'h0, link.tx_switch_output}, {31'h0, 1'bz});
    endtask
    task automatic t_supply;
        tx_sup <= 1'b0;
        frame;
        check(32'({tx_r, tx_n}), 32'h0);
        check(32'(rx_r), 32'h3FFF);
    endtask
    initial begin
        resetn_i = 1'b0;
        we_i = 1'b0;
        re_i = 1'b0;
        addr_i = 4'h0;
        wdata_i = 32'h0;
        {tx_sup, rx_sup, lock, mon, up_tx, up_rx} = 6'h3B;
        repeat (2) @(posedge clk_i);
        resetn_i <= 1'b1;
        wr(DPL_REG_CTRL, 32'h3);
        t_load;
        t_bad;
        t_status;
        t_pump;
        t_switch;
        t_supply;
        print_verdict;
    end
endmodule
`default_nettype wire
